/* File: shared/dtsc_pkg.sv */
// Constants shared by the debug trace status and control block
package dtsc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] DTSC_IDX_STATUS = 8'h21;
    localparam logic [7:0] DTSC_IDX_TRACE_CTRL = 8'h22;
    localparam logic [7:0] DTSC_IDX_MATCH_CTRL = 8'h23;
    localparam logic [7:0] DTSC_IDX_LINE_COUNT = 8'h26;
    // Field positions
    localparam int DTSC_TBF_BIT = 7;
    localparam int DTSC_TSRC_BIT = 6;
    localparam int DTSC_TMODE_LO = 2;
    localparam int DTSC_TRIGGER_ALIGNMENT_BIT = 0;
    localparam int DTSC_MAP_LO = 0;
    localparam int DTSC_SSF_LO = 0;
    // Reset values
    localparam logic [7:0] DTSC_TRACE_CTRL_RST = 8'h00;
    localparam logic [1:0] DTSC_MAP_RST = 2'h0;
    localparam logic [2:0] DTSC_SSF_RST = 3'h0;
    // Sequencer state codes
    localparam logic [2:0] DTSC_SSF_IDLE = 3'h0;
    localparam logic [2:0] DTSC_SSF_FIRST = 3'h1;
    localparam logic [2:0] DTSC_SSF_FINAL = 3'h4;
    // Trace mode codes
    localparam logic [1:0] DTSC_MODE_FLOW = 2'h0;
    localparam logic [1:0] DTSC_MODE_DEDUP = 2'h1;
    localparam logic [1:0] DTSC_MODE_ACCESS = 2'h2;
    localparam logic [1:0] DTSC_MODE_PC = 2'h3;
    // Match mapping codes
    localparam logic [1:0] DTSC_MAP_DIRECT = 2'h0;
    localparam logic [1:0] DTSC_MAP_INSIDE = 2'h1;
    localparam logic [1:0] DTSC_MAP_OUTSIDE = 2'h2;
    // Trace buffer depth in lines
    localparam logic [6:0] DTSC_FULL_LINES = 7'h40;
endpackage

/* File: verif/tb_dtsc_top.sv */
// Self-checking bench for the debug trace status and control block
`timescale 1ns/100ps
`default_nettype none
module tb_dtsc_top;
    // Stimulus towards the block
    logic clk = 1'b0, rstn = 1'b0, por = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    logic armed = 1'b0, armw = 1'b0, endi = 1'b0, sec = 1'b0, step = 1'b0;
    logic ls = 1'b0, req = 1'b0, ca = 1'b0, cb = 1'b0, ab = 1'b0, bl = 1'b0;
    logic [2:0] sst = 3'h0;
    logic [5:0] lc = 6'h2a;
    // Observed outputs
    logic [7:0] rdata;
    logic ok, ton, sf, sd, sa, sp, alb, alv, m0, m1;
    logic [2:0] flags;
    int err_total = 0, tests_run = 0, cyc = 0;
    logic [1:0] em;

    dtsc_top u_dut (.clk_in(clk), .rstn_in(rstn), .por_rstn_in(por), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .armed_in(armed),
        .arm_write_in(armw), .end_internal_in(endi), .secure_in(sec), .seq_step_in(step),
        .seq_state_in(sst), .line_stored_in(ls), .line_count_in(lc), .buf_rd_req_in(req),
        .buf_rd_ok_out(ok), .trace_on_out(ton), .store_flow_out(sf), .store_dedup_out(sd),
        .store_access_out(sa), .store_pc_out(sp), .align_begin_out(alb),
        .all_lines_valid_out(alv), .state_flags_out(flags), .comp_a_in(ca),
        .comp_b_in(cb), .above_a_in(ab), .below_b_in(bl), .match0_out(m0),
        .match1_out(m1));

    // Clock at 200 MHz
    always #2.5 clk = ~clk;

    // Prints the tallies and the verdict, then stops
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end

    // Compares one value against its expectation
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle register write
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // One-cycle register read, data checked in the following cycle
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, rdata, e);
    endtask

    // One-cycle event pulse: 0 arm write, 1 internal end, 2 step, 3 line stored
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: armw <= 1'b1;
            1: endi <= 1'b1;
            2: step <= 1'b1;
            default: ls <= 1'b1;
        endcase
        @(posedge clk);
        armw <= 1'b0;
        endi <= 1'b0;
        step <= 1'b0;
        ls <= 1'b0;
        #1;
    endtask

    // Holds the chosen resets for three cycles, then waits for the synchroniser
    task automatic do_reset(input logic with_por);
        @(posedge clk);
        rstn <= 1'b0;
        if (with_por) begin
            por <= 1'b0;
        end
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        por <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    initial begin
        do_reset(1'b1);
        rd_reg(8'h88, 8'h00, "tctrl reset");
        rd_reg(8'h90, 8'h00, "unmapped");
        wr_reg(8'h88, 8'hff);
        rd_reg(8'h88, 8'h4d, "tctrl rw");
        chk("align", alb, 8'h01);
        // Every trace mode gives exactly its own store strobe
        for (int m = 0; m < 4; m++) begin
            wr_reg(8'h88, 8'h40 | 8'(m << 2));
            chk("mode", {sf, sd, sa, sp}, 8'(4'b1000 >> m));
        end
        chk("align0", alb, 8'h00);
        // Secured: source bit frozen, tracing and buffer reads off
        @(posedge clk) sec <= 1'b1;
        req <= 1'b1;
        wr_reg(8'h88, 8'h00);
        rd_reg(8'h88, 8'h40, "tctrl secure");
        chk("trace on sec", {ton, ok}, 8'h00);
        @(posedge clk) sec <= 1'b0;
        wr_reg(8'h88, 8'h00);
        chk("rd ok clear", ok, 8'h00);
        wr_reg(8'h88, 8'h40);
        chk("rd ok set", ok, 8'h01);
        // Armed: both control registers ignore writes
        @(posedge clk) armed <= 1'b1;
        wr_reg(8'h88, 8'h0d);
        wr_reg(8'h8c, 8'h02);
        rd_reg(8'h88, 8'h40, "tctrl armed");
        rd_reg(8'h8c, 8'h00, "map armed");
        chk("rd ok armed", ok, 8'h00);
        @(posedge clk) armed <= 1'b0;
        req <= 1'b0;
        // Every mapping against every comparator combination
        for (int m = 0; m < 4; m++) begin
            wr_reg(8'h8c, 8'(m));
            rd_reg(8'h8c, 8'(m), "map rw");
            for (int i = 0; i < 16; i++) begin
                @(posedge clk);
                {ca, cb, ab, bl} <= 4'(i);
                @(posedge clk);
                #1;
                case (m)
                    0: em = {ca, cb};
                    1: em = {ab & bl, 1'b0};
                    2: em = {~(ab & bl), 1'b0};
                    default: em = {ca, 1'b0};
                endcase
                chk("match", {m0, m1}, 8'(em));
            end
        end
        // Sequencer flags through a session
        pulse(0);
        @(posedge clk) armed <= 1'b1;
        rd_reg(8'h84, 8'h01, "arm state");
        sst <= 3'h3;
        pulse(2);
        chk("step 3", flags, 8'h03);
        sst <= 3'h5;
        pulse(2);
        chk("reserved", flags, 8'h03);
        sst <= 3'h4;
        pulse(2);
        @(posedge clk) armed <= 1'b0;
        rd_reg(8'h84, 8'h04, "sw disarm");
        pulse(0);
        @(posedge clk) armed <= 1'b1;
        pulse(1);
        chk("internal end", flags, 8'h00);
        // Full flag after exactly 64 lines
        pulse(0);
        for (int n = 0; n < 63; n++) begin
            pulse(3);
        end
        @(posedge clk);
        #1;
        chk("not full", alv, 8'h00);
        pulse(3);
        @(posedge clk);
        #1;
        chk("full", alv, 8'h01);
        @(posedge clk) armed <= 1'b0;
        rd_reg(8'h98, 8'haa, "count mirror");
        do_reset(1'b0);
        rd_reg(8'h84, 8'h80, "sys reset");
        pulse(0);
        rd_reg(8'h84, 8'h01, "arm clears");
        @(posedge clk) armed <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            pulse(3);
        end
        @(posedge clk) armed <= 1'b0;
        do_reset(1'b1);
        rd_reg(8'h98, 8'h2a, "por clears");
        complete_run();
    end
endmodule
`default_nettype wire

/* File: verilog/dtsc_top.sv */
// Debug trace status, trace control and comparator match mapping
// Operation
// - Set full flag after 64 lines since arming
// - Full flag clears on arm write, POR only
// - Full flag mirrored in line counter bit 7
// - State flags follow each sequencer transition
// - Software disarm keeps last state flags
// - Internal end returns flags to zero
// - Arming forces state flags to 001
// - State codes 000 to 100, rest reserved
// - Trace source not settable while secured
// - Buffer reads need trace source set
// - Trace control write gated by armed, source bit also by secure
// - Mode 00 stores change of flow
// - Mode 01 stores flow without repeats
// - Mode 10 stores every access
// - Mode 11 stores every program counter
// - Align bit places trigger end or begin
// - Match control writable only while disarmed
// - Map 00 gives match0 A, match1 B
// - Map 01 gives match0 inside range
// - Map 10 gives match0 outside range
// - Map 11 behaves as comparator A only
// - Armed module ignores writes to these bits
`timescale 1ns/100ps
`default_nettype none
module dtsc_top (
    // Clock and resets
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic por_rstn_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // Session control from the primary control logic
    input wire logic armed_in,
    input wire logic arm_write_in,
    input wire logic end_internal_in,
    input wire logic secure_in,
    // Sequencer and trace capture
    input wire logic seq_step_in,
    input wire logic [2:0] seq_state_in,
    input wire logic line_stored_in,
    input wire logic [5:0] line_count_in,
    // Trace buffer read request
    input wire logic buf_rd_req_in,
    output logic buf_rd_ok_out,
    // Trace configuration towards capture logic
    output logic trace_on_out,
    output logic store_flow_out,
    output logic store_dedup_out,
    output logic store_access_out,
    output logic store_pc_out,
    output logic align_begin_out,
    output logic all_lines_valid_out,
    output logic [2:0] state_flags_out,
    // Comparators and match signals
    input wire logic comp_a_in,
    input wire logic comp_b_in,
    input wire logic above_a_in,
    input wire logic below_b_in,
    output logic match0_out,
    output logic match1_out
);
    import dtsc_pkg::*;

    // Register state under system reset
    typedef struct packed {
        logic tsrc;       // Trace source enable
        logic [1:0] tmode; // Trace mode select
        logic trigger_alignment;     // Trigger alignment
        logic [1:0] map;  // Comparator match map
        logic [2:0] sequencer_state_flags;  // Sequencer state flags
        logic [7:0] rdata; // Read data register
        logic m0;         // Match signal 0
        logic m1;         // Match signal 1
    } dtsc_state_t;

    // State held across system resets, cleared by power-on only
    typedef struct packed {
        logic trace_full_flag;        // Trace full flag
        logic [6:0] lines; // Lines captured since arming
    } dtsc_por_t;

    dtsc_state_t st_q;
    dtsc_state_t st_d;
    dtsc_por_t por_q;
    dtsc_por_t por_d;
    logic [1:0] rst_sync_q; // System reset release chain
    logic [1:0] por_sync_q; // Power-on reset release chain
    logic rst_n;            // Synchronised system reset
    logic por_n;            // Synchronised power-on reset

    // Byte address of a register index
    function automatic logic [7:0] reg_addr(input logic [7:0] idx);
        reg_addr = {idx[5:0], 2'b00};
    endfunction

    // Code legal for the sequencer
    function automatic logic legal_state(input logic [2:0] code);
        legal_state = (code <= DTSC_SSF_FINAL);
    endfunction

    // Release system reset through two flops
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // Release power-on reset through two flops
    always_ff @(posedge clk_in or negedge por_rstn_in) begin
        if (!por_rstn_in) begin
            por_sync_q <= 2'b00;
        end else begin
            por_sync_q <= {por_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];
    assign por_n = por_sync_q[1];

    // Address decode strobes
    logic hit_tctl;
    logic hit_mctl;
    assign hit_tctl = wr_in && (addr_in == reg_addr(DTSC_IDX_TRACE_CTRL));
    assign hit_mctl = wr_in && (addr_in == reg_addr(DTSC_IDX_MATCH_CTRL));

    // Trace allowed only when requested and unsecured
    logic trace_on;
    assign trace_on = st_q.tsrc && !secure_in;

    // Next register state
    always_comb begin
        st_d = st_q;
        if (hit_tctl && !secure_in && !armed_in) begin
            st_d.tsrc = wdata_in[DTSC_TSRC_BIT];
        end
        if (hit_tctl && !armed_in) begin
            st_d.tmode = wdata_in[DTSC_TMODE_LO +: 2];
            st_d.trigger_alignment = wdata_in[DTSC_TRIGGER_ALIGNMENT_BIT];
        end
        if (hit_mctl && !armed_in) begin
            st_d.map = wdata_in[DTSC_MAP_LO +: 2];
        end
        if (arm_write_in) begin
            st_d.sequencer_state_flags = DTSC_SSF_FIRST;
        end else if (end_internal_in) begin
            st_d.sequencer_state_flags = DTSC_SSF_IDLE;
        end else if (armed_in && seq_step_in && legal_state(seq_state_in)) begin
            st_d.sequencer_state_flags = seq_state_in;
        end
        // Read data, valid only in the cycle after the strobe
        st_d.rdata = 8'h00;
        if (rd_in) begin
            if (addr_in == reg_addr(DTSC_IDX_STATUS)) begin
                st_d.rdata[DTSC_TBF_BIT] = por_q.trace_full_flag;
                st_d.rdata[DTSC_SSF_LO +: 3] = st_q.sequencer_state_flags;
            end else if (addr_in == reg_addr(DTSC_IDX_TRACE_CTRL)) begin
                st_d.rdata[DTSC_TSRC_BIT] = st_q.tsrc;
                st_d.rdata[DTSC_TMODE_LO +: 2] = st_q.tmode;
                st_d.rdata[DTSC_TRIGGER_ALIGNMENT_BIT] = st_q.trigger_alignment;
            end else if (addr_in == reg_addr(DTSC_IDX_MATCH_CTRL)) begin
                st_d.rdata[DTSC_MAP_LO +: 2] = st_q.map;
            end else if (addr_in == reg_addr(DTSC_IDX_LINE_COUNT)) begin
                st_d.rdata[DTSC_TBF_BIT] = por_q.trace_full_flag;
                st_d.rdata[5:0] = line_count_in;
            end else begin
                // Unmapped addresses read zero
                st_d.rdata = 8'h00;
            end
        end
        // Match mapping
        unique case (st_q.map)
            DTSC_MAP_DIRECT: begin
                st_d.m0 = comp_a_in;
                st_d.m1 = comp_b_in;
            end
            DTSC_MAP_INSIDE: begin
                st_d.m0 = above_a_in && below_b_in;
                st_d.m1 = 1'b0;
            end
            DTSC_MAP_OUTSIDE: begin
                st_d.m0 = !(above_a_in && below_b_in);
                st_d.m1 = 1'b0;
            end
            default: begin
                st_d.m0 = comp_a_in;
                st_d.m1 = 1'b0;
            end
        endcase
    end

    // Next power-on state
    always_comb begin
        por_d = por_q;
        // Count restarts on each arm write
        if (arm_write_in) begin
            por_d.lines = 7'h00;
        end
        // Count captured lines up to buffer depth
        if (line_stored_in && armed_in && por_d.lines < DTSC_FULL_LINES) begin
            por_d.lines = por_d.lines + 7'h01;
        end
        if (arm_write_in) begin
            por_d.trace_full_flag = 1'b0;
        end
        // set on 64th line, set beats clear
        if (line_stored_in && armed_in && por_q.lines == DTSC_FULL_LINES - 7'h01) begin
            por_d.trace_full_flag = 1'b1;
        end
    end

    // Register update under system reset
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_q.tsrc <= DTSC_TRACE_CTRL_RST[DTSC_TSRC_BIT];
            st_q.tmode <= DTSC_TRACE_CTRL_RST[DTSC_TMODE_LO +: 2];
            st_q.trigger_alignment <= DTSC_TRACE_CTRL_RST[DTSC_TRIGGER_ALIGNMENT_BIT];
            st_q.map <= DTSC_MAP_RST;
            st_q.sequencer_state_flags <= DTSC_SSF_RST;
            st_q.rdata <= 8'h00;
            st_q.m0 <= 1'b0;
            st_q.m1 <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk_in or negedge por_n) begin
        if (!por_n) begin
            por_q <= '0;
        end else begin
            por_q <= por_d;
        end
    end

    // Outputs
    assign rdata_out = st_q.rdata;
    assign match0_out = st_q.m0;
    assign match1_out = st_q.m1;
    assign state_flags_out = st_q.sequencer_state_flags;
    assign all_lines_valid_out = por_q.trace_full_flag;
    assign trace_on_out = trace_on;
    assign store_flow_out = trace_on && (st_q.tmode == DTSC_MODE_FLOW);
    assign store_dedup_out = trace_on && (st_q.tmode == DTSC_MODE_DEDUP);
    assign store_access_out = trace_on && (st_q.tmode == DTSC_MODE_ACCESS);
    assign store_pc_out = trace_on && (st_q.tmode == DTSC_MODE_PC);
    assign align_begin_out = st_q.trigger_alignment;
    assign buf_rd_ok_out = buf_rd_req_in && trace_on && !armed_in;

    // Checks on the logic above
    a_tbf_sets: assert property (@(posedge clk_in) disable iff (!por_n)
        (line_stored_in && armed_in && por_q.lines == 7'h3f) |=> por_q.trace_full_flag)
        else $error("full flag not set at 64 lines");
    a_tbf_clears: assert property (@(posedge clk_in) disable iff (!por_n)
        (arm_write_in && !line_stored_in) |=> !por_q.trace_full_flag)
        else $error("full flag not cleared by arm write");
    a_tbf_mirror: assert property (@(posedge clk_in) disable iff (!rst_n)
        (rd_in && addr_in == 8'h98) |=> rdata_out[7] == $past(por_q.trace_full_flag))
        else $error("line counter bit 7 differs from full flag");
    a_ssf_arm: assert property (@(posedge clk_in) disable iff (!rst_n)
        arm_write_in |=> state_flags_out == 3'h1)
        else $error("arming did not force state 001");
    a_ssf_end: assert property (@(posedge clk_in) disable iff (!rst_n)
        (end_internal_in && !arm_write_in) |=> state_flags_out == 3'h0)
        else $error("internal end did not clear state");
    a_ssf_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
        (!armed_in && !arm_write_in && !end_internal_in) |=> $stable(state_flags_out))
        else $error("state flags changed while disarmed");
    a_ssf_legal: assert property (@(posedge clk_in) disable iff (!rst_n)
        state_flags_out <= 3'h4)
        else $error("reserved state code");
    a_src_secure: assert property (@(posedge clk_in) disable iff (!rst_n)
        (secure_in && !st_q.tsrc) |=> !st_q.tsrc)
        else $error("trace source set while secure");
    a_mctl_armed: assert property (@(posedge clk_in) disable iff (!rst_n)
        armed_in |=> $stable(st_q.map))
        else $error("match map written while armed");
    a_buf_gate: assert property (@(posedge clk_in) disable iff (!rst_n)
        buf_rd_ok_out |-> st_q.tsrc && !armed_in)
        else $error("buffer read allowed without trace source");
    a_map_inside: assert property (@(posedge clk_in) disable iff (!rst_n)
        (st_q.map == 2'h1) |=> !match1_out)
        else $error("match1 active in range mode");

    // Direct mapping passes both comparators through one cycle later
    a_map_direct: assert property (@(posedge clk_in) disable iff (!rst_n)
        (st_q.map == 2'h0) |=>
        (match0_out == $past(comp_a_in) && match1_out == $past(comp_b_in)))
        else $error("direct mapping wrong");

    // Outside range inverts the range term and silences match1
    a_map_outside: assert property (@(posedge clk_in) disable iff (!rst_n)
        (st_q.map == 2'h2) |=>
        (match0_out == !$past(above_a_in && below_b_in) && !match1_out))
        else $error("outside mapping wrong");

    // Reserved mapping keeps comparator A only
    a_map_reserved: assert property (@(posedge clk_in) disable iff (!rst_n)
        (st_q.map == 2'h3) |=> (match0_out == $past(comp_a_in) && !match1_out))
        else $error("reserved mapping wrong");

    // A legal step while armed is shown in the flags
    a_ssf_step: assert property (@(posedge clk_in) disable iff (!rst_n)
        (armed_in && seq_step_in && !arm_write_in && !end_internal_in &&
        seq_state_in <= 3'h4) |=> state_flags_out == $past(seq_state_in))
        else $error("state flags missed a transition");

    // A reserved code leaves the flags alone
    a_ssf_reserved: assert property (@(posedge clk_in) disable iff (!rst_n)
        (seq_step_in && seq_state_in > 3'h4 && !arm_write_in && !end_internal_in)
        |=> $stable(state_flags_out))
        else $error("reserved code taken");

    // Trace control bits frozen while armed
    a_tctl_armed: assert property (@(posedge clk_in) disable iff (!rst_n)
        armed_in |=> $stable({st_q.tsrc, st_q.tmode, st_q.trigger_alignment}))
        else $error("trace control written while armed");

    // Secure mode shuts tracing off at once
    a_trace_gate: assert property (@(posedge clk_in) disable iff (!rst_n)
        secure_in |-> !trace_on_out)
        else $error("tracing while secure");

    // Mode 00 raises the flow strobe
    a_mode_flow: assert property (@(posedge clk_in) disable iff (!rst_n)
        (trace_on_out && st_q.tmode == 2'h0) |-> (store_flow_out && !store_dedup_out))
        else $error("flow mode strobe wrong");

    // Mode 01 raises the repeat-free strobe
    a_mode_dedup: assert property (@(posedge clk_in) disable iff (!rst_n)
        (trace_on_out && st_q.tmode == 2'h1) |-> (store_dedup_out && !store_flow_out))
        else $error("dedup mode strobe wrong");

    // Mode 10 raises the access strobe
    a_mode_access: assert property (@(posedge clk_in) disable iff (!rst_n)
        (trace_on_out && st_q.tmode == 2'h2) |-> (store_access_out && !store_pc_out))
        else $error("access mode strobe wrong");

    // Mode 11 raises the program counter strobe
    a_mode_pc: assert property (@(posedge clk_in) disable iff (!rst_n)
        (trace_on_out && st_q.tmode == 2'h3) |-> (store_pc_out && !store_access_out))
        else $error("pc mode strobe wrong");

    // Read data only stands in the cycle after a read strobe
    a_rdata_idle: assert property (@(posedge clk_in) disable iff (!rst_n)
        !rd_in |=> rdata_out == 8'h00)
        else $error("read data outside its cycle");
endmodule
`default_nettype wire
